// File: design/line_irq_pkg.sv
// constants for the per-channel interrupt mask and status block
package line_irq_pkg;
  // register offsets
  localparam logic [7:0] EDGE_SEL_OFF  = 8'h1a;
  localparam logic [7:0] MASK_A_OFF    = 8'h1b;
  localparam logic [7:0] MASK_B_OFF    = 8'h1c;
  localparam logic [7:0] MASK_C_OFF    = 8'h1d;
  localparam logic [7:0] LIVE_A_OFF    = 8'h1e;
  localparam logic [7:0] LIVE_B_OFF    = 8'h1f;
  localparam logic [7:0] LATCH_A_OFF   = 8'h20;
  localparam logic [7:0] LATCH_B_OFF   = 8'h21;
  localparam logic [7:0] LATCH_C_OFF   = 8'h22;
  // reset values
  localparam logic [7:0] EDGE_SEL_RST  = 8'h00;
  localparam logic [7:0] MASK_A_RST    = 8'hff;
  localparam logic [7:0] MASK_B_RST    = 8'hef;
  localparam logic [7:0] MASK_C_RST    = 8'h3f;
  localparam logic [7:0] LIVE_A_RST    = 8'h00;
  localparam logic [7:0] LATCH_RST     = 8'h00;
  // implemented bits
  localparam logic [7:0] EDGE_SEL_IMPL = 8'h7f;
  localparam logic [7:0] MASK_B_IMPL   = 8'he3;
  localparam logic [7:0] MASK_C_IMPL   = 8'h3f;
  localparam logic [7:0] LIVE_A_IMPL   = 8'h9f;
  localparam logic [7:0] LIVE_B_IMPL   = 8'he3;
  // group a bit positions
  localparam int AMP_OVF_BIT  = 7;
  localparam int TX_FIFO_BIT  = 6;
  localparam int RX_FIFO_BIT  = 5;
  localparam int OVERCUR_BIT  = 4;
  localparam int TX_CLK_BIT   = 3;
  localparam int TX_LOSS_BIT  = 2;
  localparam int SYS_LOSS_BIT = 1;
  localparam int LN_LOSS_BIT  = 0;
  localparam int AUTO_LP_BIT  = 7;
  // edge select bit positions
  localparam int SEL_AIS_BIT  = 6;
  localparam int SEL_PAT_BIT  = 5;
  localparam int SEL_OC_BIT   = 4;
  localparam int SEL_CLK_BIT  = 3;
  localparam int SEL_TX_BIT   = 2;
  localparam int SEL_LOS_BIT  = 1;
  localparam int SEL_IB_BIT   = 0;
  localparam int GROUPS       = 3;
endpackage

// File: design/line_channel_irq_mask_status.sv
// per-channel interrupt mask, live status and latched flag logic
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module line_channel_irq_mask_status
  import line_irq_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  output logic      [7:0] rd_data_o,
  // live conditions
  input  wire logic       auto_loopback_state_i,
  input  wire logic       driver_overcurrent_state_i,
  input  wire logic       tx_clock_missing_state_i,
  input  wire logic       tx_signal_loss_state_i,
  input  wire logic       system_signal_loss_state_i,
  input  wire logic       line_signal_loss_state_i,
  input  wire logic       system_alarm_indication_i,
  input  wire logic       line_alarm_indication_i,
  input  wire logic       pattern_sync_i,
  input  wire logic       loop_activate_code_i,
  input  wire logic       loop_deactivate_code_i,
  // one-cycle event pulses
  input  wire logic       amplitude_overflow_i,
  input  wire logic       tx_jitter_fifo_fault_i,
  input  wire logic       rx_jitter_fifo_fault_i,
  input  wire logic       system_bipolar_violation_i,
  input  wire logic       line_bipolar_violation_i,
  input  wire logic       system_excess_zeros_i,
  input  wire logic       line_excess_zeros_i,
  input  wire logic       pattern_error_i,
  input  wire logic       error_counter_overflow_i,
  // interrupt
  output logic            irq_o
);

  logic [7:0] edge_sel;
  logic [7:0] mask [GROUPS];
  logic [7:0] latched [GROUPS];
  logic [7:0] set_v [GROUPS];
  logic [7:0] clr_v [GROUPS];
  logic [7:0] live_a;
  logic [7:0] live_b;
  logic [7:0] prev_a;
  logic [7:0] prev_b;
  logic [7:0] sel_a;
  logic [7:0] sel_b;
  logic [7:0] edge_a;
  logic [7:0] edge_b;
  logic       next_irq;

  // live condition vectors
  always_comb begin
    live_a = {auto_loopback_state_i, 2'b00, driver_overcurrent_state_i,
              tx_clock_missing_state_i,
              tx_signal_loss_state_i, system_signal_loss_state_i,
              line_signal_loss_state_i};
    live_b = {system_alarm_indication_i, line_alarm_indication_i, pattern_sync_i,
              3'b000, loop_activate_code_i, loop_deactivate_code_i};
  end

  // previous live values for edge detection
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prev_a <= LIVE_A_RST;
      prev_b <= 8'h00;
    end else begin
      prev_a <= live_a;
      prev_b <= live_b;
    end
  end

  // per-bit edge choice: rise only, or any transition
  always_comb begin
    sel_a = {3'b000, edge_sel[SEL_OC_BIT], edge_sel[SEL_CLK_BIT], edge_sel[SEL_TX_BIT],
             {2{edge_sel[SEL_LOS_BIT]}}};
    sel_b = {{2{edge_sel[SEL_AIS_BIT]}}, edge_sel[SEL_PAT_BIT], 3'b000,
             {2{edge_sel[SEL_IB_BIT]}}};
    edge_a = (live_a & ~prev_a) | (sel_a & (live_a ^ prev_a));
    edge_b = (live_b & ~prev_b) | (sel_b & (live_b ^ prev_b));
  end

  // set sources for each latched group
  always_comb begin
    set_v[0] = {amplitude_overflow_i, tx_jitter_fifo_fault_i, rx_jitter_fifo_fault_i,
                edge_a[4:0]};
    set_v[1] = edge_b & LIVE_B_IMPL;
    set_v[2] = {2'b00, system_bipolar_violation_i, line_bipolar_violation_i,
                system_excess_zeros_i, line_excess_zeros_i, pattern_error_i,
                error_counter_overflow_i};
  end

  // write-one-to-clear vectors
  always_comb begin
    clr_v[0] = (wr_en_i && addr_i == LATCH_A_OFF) ? wr_data_i : 8'h00;
    clr_v[1] = (wr_en_i && addr_i == LATCH_B_OFF) ? wr_data_i : 8'h00;
    clr_v[2] = (wr_en_i && addr_i == LATCH_C_OFF) ? wr_data_i : 8'h00;
  end

  // latched flags, set wins over clear
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : grp
      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
          latched[g] <= LATCH_RST;
        end else begin
          latched[g] <= (latched[g] & ~clr_v[g]) | set_v[g];
        end
      end
    end
  endgenerate

  // edge select register
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      edge_sel <= EDGE_SEL_RST;
    end else if (wr_en_i && addr_i == EDGE_SEL_OFF) begin
      edge_sel <= wr_data_i & EDGE_SEL_IMPL;
    end
  end

  // mask registers; reserved bits hold their reset value
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mask[0] <= MASK_A_RST;
      mask[1] <= MASK_B_RST;
      mask[2] <= MASK_C_RST;
    end else if (wr_en_i) begin
      if (addr_i == MASK_A_OFF) begin
        mask[0] <= wr_data_i;
      end
      if (addr_i == MASK_B_OFF) begin
        mask[1] <= (wr_data_i & MASK_B_IMPL) | (MASK_B_RST & ~MASK_B_IMPL);
      end
      if (addr_i == MASK_C_OFF) begin
        mask[2] <= wr_data_i & MASK_C_IMPL;
      end
    end
  end

  // unmasked flags drive the interrupt
  always_comb begin
    next_irq = |(latched[0] & ~mask[0]) | |(latched[1] & ~mask[1])
             | |(latched[2] & ~mask[2]);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      unique case (addr_i)
        EDGE_SEL_OFF: rd_data_o <= edge_sel;
        MASK_A_OFF:   rd_data_o <= mask[0];
        MASK_B_OFF:   rd_data_o <= mask[1];
        MASK_C_OFF:   rd_data_o <= mask[2];
        LIVE_A_OFF:   rd_data_o <= live_a & LIVE_A_IMPL;
        LIVE_B_OFF:   rd_data_o <= live_b & LIVE_B_IMPL;
        LATCH_A_OFF:  rd_data_o <= latched[0];
        LATCH_B_OFF:  rd_data_o <= latched[1];
        LATCH_C_OFF:  rd_data_o <= latched[2];
        default:      rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence wr_mask_a_s;
    wr_en_i && addr_i == MASK_A_OFF;
  endsequence

  sequence rd_mask_a_s;
    rd_en_i && addr_i == MASK_A_OFF;
  endsequence

  mask_a_reset_a: assert property ($fell(sys_rst_i) |-> mask[0] == 8'hff)
    else $error("mask a reset value wrong");

  mask_bc_reset_a: assert property ($fell(sys_rst_i) |-> mask[1] == 8'hef && mask[2] == 8'h3f)
    else $error("mask b or c reset value wrong");

  mask_a_readback_a: assert property (wr_mask_a_s ##1 rd_mask_a_s |=> rd_data_o == $past(wr_data_i, 2))
    else $error("mask a readback mismatch");

  mask_b_reserved_a: assert property (mask[1][4:2] == 3'b011)
    else $error("mask b reserved bits changed");

  mask_c_reserved_a: assert property (mask[2][7:6] == 2'b00)
    else $error("mask c reserved bits not zero");

  live_a_read_a: assert property (rd_en_i && addr_i == LIVE_A_OFF |=>
      rd_data_o == {$past(auto_loopback_state_i), 2'b00, $past(driver_overcurrent_state_i),
                    $past(tx_clock_missing_state_i), $past(tx_signal_loss_state_i),
                    $past(system_signal_loss_state_i), $past(line_signal_loss_state_i)})
    else $error("live status a read wrong");

  rd_idle_zero_a: assert property (!rd_en_i |=> rd_data_o == 8'h00)
    else $error("read data not zero outside read cycle");

  rise_sets_flag_a: assert property ($rose(driver_overcurrent_state_i) |=> latched[0][4])
    else $error("rising over-current did not set flag");

  fall_select_a: assert property ($fell(line_alarm_indication_i) && edge_sel[SEL_AIS_BIT] |=> latched[1][6])
    else $error("falling alarm with edge select did not set flag");

  fall_ignored_a: assert property ($fell(tx_clock_missing_state_i) && !edge_sel[SEL_CLK_BIT]
      && !latched[0][3] |=> !latched[0][3])
    else $error("falling clock missing set flag without edge select");

  set_wins_a: assert property (pattern_error_i && wr_en_i && addr_i == LATCH_C_OFF && wr_data_i[1]
      |=> latched[2][1])
    else $error("clear beat a simultaneous set");

  w1c_clears_a: assert property (wr_en_i && addr_i == LATCH_C_OFF && wr_data_i[0]
      && !error_counter_overflow_i |=> !latched[2][0])
    else $error("write one did not clear flag");

  irq_unmasked_a: assert property (latched[2][5] && !mask[2][5] |=> irq_o)
    else $error("unmasked flag did not raise interrupt");

  irq_masked_a: assert property (mask[0] == 8'hff && mask[1] == 8'hef && mask[2] == 8'h3f
      |=> !irq_o)
    else $error("interrupt raised with all sources masked");

  irq_amp_a: assert property (amplitude_overflow_i && !mask[0][7] ##1 !mask[0][7] |=> irq_o)
    else $error("amplitude overflow not reported");

  // register port steps
  sequence wr_mask_b_s;
    wr_en_i && addr_i == MASK_B_OFF;
  endsequence

  sequence wr_mask_c_s;
    wr_en_i && addr_i == MASK_C_OFF;
  endsequence

  sequence rd_mask_b_s;
    rd_en_i && addr_i == MASK_B_OFF;
  endsequence

  sequence rd_mask_c_s;
    rd_en_i && addr_i == MASK_C_OFF;
  endsequence

  // over-current rise with its mask open, then the flag cycle
  sequence oc_rise_open_s;
    $rose(driver_overcurrent_state_i) && !mask[0][4];
  endsequence

  sequence oc_mask_open_s;
    !mask[0][4];
  endsequence

  // state right after reset release
  edge_sel_reset_a: assert property ($fell(sys_rst_i) |-> edge_sel == 8'h00)
    else $error("edge select reset value wrong");

  latched_reset_a: assert property ($fell(sys_rst_i) |->
      latched[0] == 8'h00 && latched[1] == 8'h00 && latched[2] == 8'h00)
    else $error("latched flags not clear after reset");

  irq_reset_a: assert property ($fell(sys_rst_i) |-> !irq_o)
    else $error("interrupt high after reset");

  rd_reset_a: assert property ($fell(sys_rst_i) |-> rd_data_o == 8'h00)
    else $error("read data not zero after reset");

  // mask register writes and reads
  mask_a_write_a: assert property (wr_mask_a_s |=> mask[0] == $past(wr_data_i))
    else $error("mask a write lost");

  mask_a_hold_a: assert property (!(wr_en_i && addr_i == MASK_A_OFF) |=> $stable(mask[0]))
    else $error("mask a changed without a write");

  mask_b_write_a: assert property (wr_mask_b_s |=> mask[1] == (($past(wr_data_i) & 8'he3) | 8'h0c))
    else $error("mask b write wrong");

  mask_c_write_a: assert property (wr_mask_c_s |=> mask[2] == {2'b00, $past(wr_data_i[5:0])})
    else $error("mask c write wrong");

  rd_mask_b_a: assert property (rd_mask_b_s |=> rd_data_o == $past(mask[1]))
    else $error("mask b read wrong");

  rd_mask_c_a: assert property (rd_mask_c_s |=> rd_data_o == $past(mask[2]))
    else $error("mask c read wrong");

  live_a_reserved_a: assert property (rd_en_i && addr_i == LIVE_A_OFF |=> rd_data_o[6:5] == 2'b00)
    else $error("status a reserved bits not zero");

  // flag setting
  rise_loss_a: assert property ($rose(line_signal_loss_state_i) |=> latched[0][0])
    else $error("rising line signal loss did not set flag");

  pulse_cnt_a: assert property (error_counter_overflow_i |=> latched[2][0])
    else $error("counter overflow pulse did not set flag");

  pulse_fifo_a: assert property (tx_jitter_fifo_fault_i |=> latched[0][6])
    else $error("transmit fifo fault did not set flag");

  flag_hold_a: assert property (latched[0][4] && !(wr_en_i && addr_i == LATCH_A_OFF) |=> latched[0][4])
    else $error("over-current flag dropped without a clear");

  clr_oc_a: assert property (wr_en_i && addr_i == LATCH_A_OFF && wr_data_i[4] && !edge_a[4]
      |=> !latched[0][4])
    else $error("write one did not clear over-current flag");

  // unmasked flags reach the interrupt
  oc_to_irq_a: assert property (oc_rise_open_s ##1 oc_mask_open_s |=> irq_o)
    else $error("over-current rise not reported");

  irq_fifo_a: assert property (latched[0][5] && !mask[0][5] |=> irq_o)
    else $error("receive fifo flag not reported");

  irq_overcur_a: assert property (latched[0][4] && !mask[0][4] |=> irq_o)
    else $error("over-current flag not reported");

  irq_clk_a: assert property (latched[0][3] && !mask[0][3] |=> irq_o)
    else $error("clock missing flag not reported");

  irq_loss_a: assert property (latched[0][0] && !mask[0][0] |=> irq_o)
    else $error("line signal loss flag not reported");

  irq_alarm_a: assert property (latched[1][7] && !mask[1][7] |=> irq_o)
    else $error("system alarm flag not reported");

  irq_pattern_a: assert property (latched[1][5] && !mask[1][5] |=> irq_o)
    else $error("pattern sync flag not reported");

  irq_loop_a: assert property (latched[1][1] && !mask[1][1] |=> irq_o)
    else $error("loop activate flag not reported");

  irq_zeros_a: assert property (latched[2][2] && !mask[2][2] |=> irq_o)
    else $error("line excess zeros flag not reported");

  irq_err_a: assert property (latched[2][1] && !mask[2][1] |=> irq_o)
    else $error("pattern error flag not reported");

  irq_cnt_a: assert property (latched[2][0] && !mask[2][0] |=> irq_o)
    else $error("counter overflow flag not reported");

  irq_quiet_a: assert property (latched[0] == 8'h00 && latched[1] == 8'h00 && latched[2] == 8'h00
      |=> !irq_o)
    else $error("interrupt high with no flag set");

endmodule
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the channel interrupt mask and status block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import line_irq_pkg::*;
  logic       clk    = 1'b0;
  logic       rst    = 1'b1;
  logic [7:0] addr   = 8'h00;
  logic [7:0] wdata  = 8'h00;
  logic       wr     = 1'b0;
  logic       rd     = 1'b0;
  logic [7:0] rdata;
  logic       irq;
  logic [7:0] live_a = 8'h00;
  logic [7:0] live_b = 8'h00;
  logic [7:0] ev_a   = 8'h00;
  logic [7:0] ev_c   = 8'h00;
  int         n_mismatch = 0;
  int         cmp_count  = 0;
  int         cycles     = 0;

  line_channel_irq_mask_status DUT (
    .core_clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr), .rd_en_i(rd),
    .rd_data_o(rdata), .irq_o(irq),
    .auto_loopback_state_i(live_a[7]), .driver_overcurrent_state_i(live_a[4]),
    .tx_clock_missing_state_i(live_a[3]), .tx_signal_loss_state_i(live_a[2]),
    .system_signal_loss_state_i(live_a[1]), .line_signal_loss_state_i(live_a[0]),
    .system_alarm_indication_i(live_b[7]), .line_alarm_indication_i(live_b[6]), .pattern_sync_i(live_b[5]),
    .loop_activate_code_i(live_b[1]), .loop_deactivate_code_i(live_b[0]),
    .amplitude_overflow_i(ev_a[7]), .tx_jitter_fifo_fault_i(ev_a[6]), .rx_jitter_fifo_fault_i(ev_a[5]),
    .system_bipolar_violation_i(ev_c[5]), .line_bipolar_violation_i(ev_c[4]), .system_excess_zeros_i(ev_c[3]),
    .line_excess_zeros_i(ev_c[2]), .pattern_error_i(ev_c[1]), .error_counter_overflow_i(ev_c[0])
  );

  always #5 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk8(what, exp, rdata);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_src(input int g, input int b, input logic v);
    case (g)
      0: if (b >= 5) ev_a[b] <= v; else live_a[b] <= v;
      1: live_b[b] <= v;
      default: ev_c[b] <= v;
    endcase
  endtask

  task automatic t_reset_values;
    rd_chk("mask a reset", MASK_A_OFF, 8'hff);
    rd_chk("mask b reset", MASK_B_OFF, 8'hef);
    rd_chk("mask c reset", MASK_C_OFF, 8'h3f);
    rd_chk("status a reset", LIVE_A_OFF, 8'h00);
    wait_cyc(1);
    chk8("read data idle", 8'h00, rdata);
    chk1("irq after reset", 1'b0, irq);
  endtask

  task automatic t_mask_rw;
    reg_wr(MASK_A_OFF, 8'h00);
    rd_chk("mask a write", MASK_A_OFF, 8'h00);
    reg_wr(MASK_A_OFF, 8'hff);
    reg_wr(MASK_B_OFF, 8'h00);
    rd_chk("mask b reserved", MASK_B_OFF, 8'h0c);
    reg_wr(MASK_B_OFF, 8'hef);
    reg_wr(MASK_C_OFF, 8'hff);
    rd_chk("mask c reserved", MASK_C_OFF, 8'h3f);
    rd_chk("unmapped read", 8'h40, 8'h00);
  endtask

  // each source: latch while masked, unmask, clear, fall
  task automatic t_sources;
    logic [7:0] impl;
    logic [7:0] mrst;
    logic [7:0] bit_v;
    for (int g = 0; g < GROUPS; g++) begin
      impl = (g == 0) ? 8'hff : (g == 1) ? MASK_B_IMPL : MASK_C_IMPL;
      mrst = (g == 0) ? MASK_A_RST : (g == 1) ? MASK_B_RST : MASK_C_RST;
      for (int b = 0; b < 8; b++) begin
        if (impl[b]) begin
          bit_v = 8'h01 << b;
          @(posedge clk);
          set_src(g, b, 1'b1);
          if (g == 2 || (g == 0 && b >= 5)) begin
            @(posedge clk);
            set_src(g, b, 1'b0);
          end
          wait_cyc(3);
          chk1("irq while masked", 1'b0, irq);
          rd_chk("flag latched", LATCH_A_OFF + 8'(g), bit_v);
          reg_wr(MASK_A_OFF + 8'(g), mrst & ~bit_v);
          wait_cyc(3);
          chk1("irq unmasked", 1'b1, irq);
          reg_wr(LATCH_A_OFF + 8'(g), bit_v);
          wait_cyc(3);
          chk1("irq after clear", 1'b0, irq);
          @(posedge clk);
          set_src(g, b, 1'b0);
          wait_cyc(3);
          rd_chk("no flag on fall", LATCH_A_OFF + 8'(g), 8'h00);
          reg_wr(MASK_A_OFF + 8'(g), mrst);
        end
      end
    end
  endtask

  task automatic t_either_edge;
    reg_wr(EDGE_SEL_OFF, 8'h10);
    rd_chk("edge select", EDGE_SEL_OFF, 8'h10);
    @(posedge clk);
    live_a[4] <= 1'b1;
    wait_cyc(3);
    reg_wr(LATCH_A_OFF, 8'h10);
    rd_chk("flag cleared", LATCH_A_OFF, 8'h00);
    @(posedge clk);
    live_a[4] <= 1'b0;
    wait_cyc(3);
    rd_chk("flag on fall", LATCH_A_OFF, 8'h10);
    reg_wr(LATCH_A_OFF, 8'h10);
    reg_wr(EDGE_SEL_OFF, 8'h00);
  endtask

  task automatic t_live_status;
    @(posedge clk);
    live_a <= 8'h95;
    wait_cyc(2);
    rd_chk("live status", LIVE_A_OFF, 8'h95);
    @(posedge clk);
    live_a <= 8'h0a;
    wait_cyc(2);
    rd_chk("live status", LIVE_A_OFF, 8'h0a);
    reg_wr(LIVE_A_OFF, 8'hff);
    rd_chk("status read only", LIVE_A_OFF, 8'h0a);
    chk1("irq all masked", 1'b0, irq);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_mask_rw();
    t_sources();
    t_either_edge();
    t_live_status();
    complete_run();
  end
endmodule
`default_nettype wire
